// *** design/usdp_chan_if.sv ***
// character store handshake between the port logic and its stores
`timescale 1ns/1ns
interface usdp_chan_if;
    logic               push;   // write a character
    logic               pop;    // drop the head character
    logic               flush;  // empty the store
    usdp_pkg::usdp_char_t wdata; // character to write
    usdp_pkg::usdp_char_t rdata; // head character
    logic               full;   // no room left
    logic               empty;  // nothing stored

    modport store (input push, pop, flush, wdata, output rdata, full, empty);
    modport user  (output push, pop, flush, wdata, input rdata, full, empty);
endinterface : usdp_chan_if

// *** design/usdp_consts.svh ***
// offsets, field positions, reset values and sizes of the shadow data port
`ifndef USDP_CONSTS_SVH
`define USDP_CONSTS_SVH

// sixteen aliased shadow locations, one aligned word each
`define USDP_SHADOW_FIRST   32'h5000_1030
`define USDP_SHADOW_3       32'h5000_103c
`define USDP_SHADOW_4       32'h5000_1040
`define USDP_SHADOW_LAST    32'h5000_106c

// control and status words placed just above the shadow block
`define USDP_CTRL_OFS       32'h5000_1070
`define USDP_STAT_OFS       32'h5000_1074

// control field positions
`define USDP_CTRL_FIFO_EN   0
`define USDP_CTRL_IR_MODE   1

// status field positions
`define USDP_STAT_RX_AVAIL  0
`define USDP_STAT_OVERRUN   1
`define USDP_STAT_RX_FULL   2
`define USDP_STAT_TX_FULL   3
`define USDP_STAT_TX_EMPTY  5

// reset values
`define USDP_CTRL_RESET     2'h0
`define USDP_DATA_RESET     8'h00

// fifo sizing
`define USDP_PTR_W          4
`define USDP_FIFO_DEPTH     5'h10

`endif

// *** design/usdp_fifo.sv ***
// sixteen-deep character fifo; a push to a full store is dropped unless a pop frees a slot that cycle
`timescale 1ns/1ns
`include "usdp_consts.svh"
module usdp_fifo (
    input  wire logic   mclk_i,     // system clock
    input  wire logic   reset_n_i,  // async reset, active low
    usdp_chan_if.store  ch          // store side of the channel
);
    usdp_pkg::usdp_char_t          mem [16];  // character array
    logic [`USDP_PTR_W-1:0]        wr_ptr_r;  // next free slot
    logic [`USDP_PTR_W-1:0]        rd_ptr_r;  // head slot
    logic [`USDP_PTR_W:0]          count_r;   // characters held
    logic                          do_pop;    // pop accepted
    logic                          do_push;   // push accepted

    // a push while full is still taken when a pop frees a slot that cycle
    assign do_pop   = ch.pop & ~ch.empty;
    assign do_push  = ch.push & (~ch.full | do_pop);
    assign ch.full  = (count_r == `USDP_FIFO_DEPTH);
    assign ch.empty = (count_r == '0);
    assign ch.rdata = mem[rd_ptr_r];

    // storage needs no reset; only the pointers define content
    always_ff @(posedge mclk_i) begin
        if (do_push) begin
            mem[wr_ptr_r] <= ch.wdata;
        end
    end

    // pointers and occupancy
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else if (ch.flush) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            count_r <= count_r + {4'h0, do_push} - {4'h0, do_pop};
        end
    end
endmodule : usdp_fifo

// *** design/usdp_hold.sv ***
// single character holding register; a push always overwrites
`timescale 1ns/1ns
`include "usdp_consts.svh"
module usdp_hold (
    input  wire logic   mclk_i,     // system clock
    input  wire logic   reset_n_i,  // async reset, active low
    usdp_chan_if.store  ch          // store side of the channel
);
    usdp_pkg::usdp_char_t data_r;   // held character
    logic                 valid_r;  // character present

    assign ch.rdata = data_r;
    assign ch.full  = valid_r;
    assign ch.empty = ~valid_r;

    // push beats pop in the same cycle so a fresh character is never lost
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            data_r  <= `USDP_DATA_RESET;
            valid_r <= 1'b0;
        end else if (ch.flush) begin
            valid_r <= 1'b0;
        end else begin
            if (ch.push) begin
                data_r <= ch.wdata;
            end
            valid_r <= ch.push | (valid_r & ~ch.pop);
        end
    end
endmodule : usdp_hold

// *** design/usdp_pkg.sv ***
// types shared by the shadow data port modules
package usdp_pkg;

    typedef logic [7:0] usdp_char_t;        // one character

    typedef enum logic {
        BUS_IDLE,                           // waiting for a request
        BUS_ANSWER                          // answer presented, waitrequest low
    } usdp_bus_state_t;

endpackage : usdp_pkg

// *** design/usdp_port.sv ***
// shadow receive/transmit data port with avalon-mm register access
`timescale 1ns/1ns
`include "usdp_consts.svh"
module usdp_port (
    input  wire logic        mclk_i,            // 10 mhz system clock
    input  wire logic        reset_n_i,         // async reset, active low
    input  wire logic [31:0] avs_address_i,     // byte address
    input  wire logic        avs_read_i,        // read request
    input  wire logic        avs_write_i,       // write request
    input  wire logic [31:0] avs_writedata_i,   // write data
    input  wire logic [3:0]  avs_byteenable_i,  // byte lanes
    output logic      [31:0] avs_readdata_o,    // read data
    output logic             avs_waitrequest_o, // high until answered
    input  wire logic [7:0]  sin_char_i,        // char from serial receiver
    input  wire logic        sin_char_valid_i,  // serial char strobe
    input  wire logic [7:0]  sir_char_i,        // char from infrared receiver
    input  wire logic        sir_char_valid_i,  // infrared char strobe
    input  wire logic        tx_busy_i,         // serialiser busy
    output logic      [7:0]  tx_char_o,         // char to serialise
    output logic             tx_start_o,        // one-cycle start pulse
    output logic             tx_ir_sel_o        // send on infrared output
);

    // register and bus state
    usdp_pkg::usdp_bus_state_t bus_state_r;     // bus answer sequencer
    logic                   waitrequest_r;      // registered waitrequest
    logic [31:0]            readdata_r;         // registered read data
    logic                   pop_ok_r;           // head was valid when sampled
    logic                   fifo_en_r;          // fifo enable control bit
    logic                   ir_mode_r;          // infrared mode control bit
    logic                   overrun_r;          // sticky overrun flag
    usdp_pkg::usdp_char_t   tx_char_r;          // char given to serialiser
    logic                   tx_start_r;         // start pulse register

    // decoded bus events
    logic                   accept;             // request completes this edge
    logic                   acc_rd_shadow;      // accepted shadow read
    logic                   acc_wr_shadow;      // accepted shadow write
    logic                   acc_wr_ctrl;        // accepted control write
    logic                   acc_rd_stat;        // accepted status read
    logic                   flush;              // fifo mode change flush

    // receive path
    logic                   rx_stb;             // char arrives this cycle
    usdp_pkg::usdp_char_t   rx_char;            // arriving char
    usdp_pkg::usdp_char_t   rx_head;            // char a read returns
    logic                   rx_empty;           // nothing to read
    logic                   rx_full;            // store has no room
    logic                   rx_pop;             // read consumes head
    logic                   overrun_set;        // overrun event

    // transmit path
    usdp_pkg::usdp_char_t   tx_head;            // next char to send
    logic                   tx_empty;           // holding empty flag
    logic                   tx_full;            // transmit store full
    logic                   tx_pop;             // char handed to serialiser

    // character stores; the mode bit picks which pair is live
    usdp_chan_if rx_fifo_ch ();
    usdp_chan_if rx_hold_ch ();
    usdp_chan_if tx_fifo_ch ();
    usdp_chan_if tx_hold_ch ();

    // shadow window decode, used by both read and write paths
    function automatic logic is_shadow(input logic [31:0] addr);
        is_shadow = (addr >= `USDP_SHADOW_FIRST) && (addr <= `USDP_SHADOW_LAST)
                    && (addr[1:0] == 2'h0);
    endfunction : is_shadow

    // read data for any address; unmapped words answer zero
    function automatic logic [31:0] read_word(
        input logic [31:0]          addr,
        input usdp_pkg::usdp_char_t head,
        input logic [7:0]           stat,
        input logic [1:0]           ctrl
    );
        read_word = 32'h0000_0000;
        if (is_shadow(addr)) begin
            read_word = {24'h00_0000, head};
        end else if (addr == `USDP_CTRL_OFS) begin
            read_word = {30'h0000_0000, ctrl};
        end else if (addr == `USDP_STAT_OFS) begin
            read_word = {24'h00_0000, stat};
        end
    endfunction : read_word

    // status byte built from the live flags
    logic [7:0] stat_byte;                      // status word low byte
    always_comb begin
        stat_byte = 8'h00;
        stat_byte[`USDP_STAT_RX_AVAIL] = ~rx_empty;
        stat_byte[`USDP_STAT_OVERRUN]  = overrun_r;
        stat_byte[`USDP_STAT_RX_FULL]  = rx_full;
        stat_byte[`USDP_STAT_TX_FULL]  = tx_full;
        stat_byte[`USDP_STAT_TX_EMPTY] = tx_empty;
    end

    // ------------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------------

    // a request completes on the edge where waitrequest is already low
    assign accept        = (avs_read_i | avs_write_i) & (bus_state_r == usdp_pkg::BUS_ANSWER);
    assign acc_rd_shadow = accept & avs_read_i & is_shadow(avs_address_i);
    assign acc_wr_shadow = accept & avs_write_i & avs_byteenable_i[0]
                           & is_shadow(avs_address_i);
    assign acc_wr_ctrl   = accept & avs_write_i & avs_byteenable_i[0]
                           & (avs_address_i == `USDP_CTRL_OFS);
    assign acc_rd_stat   = accept & avs_read_i & (avs_address_i == `USDP_STAT_OFS);

    // changing the fifo enable empties every store, as the two modes
    // hold characters in different places
    assign flush = acc_wr_ctrl & (avs_writedata_i[`USDP_CTRL_FIFO_EN] != fifo_en_r);

    // two-state sequencer: sample the request, then answer for one cycle;
    // read data is captured when sampled so it stands at the accept edge
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bus_state_r   <= usdp_pkg::BUS_IDLE;
            waitrequest_r <= 1'b1;
            readdata_r    <= 32'h0000_0000;
            pop_ok_r      <= 1'b0;
        end else begin
            unique case (bus_state_r)
                usdp_pkg::BUS_IDLE: begin
                    if (avs_read_i | avs_write_i) begin
                        bus_state_r   <= usdp_pkg::BUS_ANSWER;
                        waitrequest_r <= 1'b0;
                        pop_ok_r      <= ~rx_empty;
                        if (avs_read_i) begin
                            readdata_r <= read_word(avs_address_i, rx_head, stat_byte,
                                                    {ir_mode_r, fifo_en_r});
                        end
                    end
                end
                usdp_pkg::BUS_ANSWER: begin
                    // master releases after the accept edge
                    bus_state_r   <= usdp_pkg::BUS_IDLE;
                    waitrequest_r <= 1'b1;
                end
            endcase
        end
    end

    // control word: fifo enable and infrared mode
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            {ir_mode_r, fifo_en_r} <= `USDP_CTRL_RESET;
        end else if (acc_wr_ctrl) begin
            fifo_en_r <= avs_writedata_i[`USDP_CTRL_FIFO_EN];
            ir_mode_r <= avs_writedata_i[`USDP_CTRL_IR_MODE];
        end
    end

    // ------------------------------------------------------------------
    // receive path
    // ------------------------------------------------------------------

    // receivers sit on this clock, so their strobes need no synchroniser
    assign rx_stb  = ir_mode_r ? sir_char_valid_i : sin_char_valid_i;
    assign rx_char = ir_mode_r ? sir_char_i : sin_char_i;

    // head, empty and full follow the live store
    assign rx_head  = fifo_en_r ? rx_fifo_ch.rdata : rx_hold_ch.rdata;
    assign rx_empty = fifo_en_r ? rx_fifo_ch.empty : rx_hold_ch.empty;
    assign rx_full  = fifo_en_r ? rx_fifo_ch.full  : rx_hold_ch.full;

    // only a read that saw a valid head consumes it; a char landing in
    // between belongs to the next read
    assign rx_pop = acc_rd_shadow & pop_ok_r;

    // no fifo: the holding register takes every char and the old one is
    // lost; fifo: the store refuses a push when full and unread
    assign rx_hold_ch.push  = rx_stb & ~fifo_en_r;
    assign rx_hold_ch.pop   = rx_pop & ~fifo_en_r;
    assign rx_hold_ch.flush = flush;
    assign rx_hold_ch.wdata = rx_char;
    assign rx_fifo_ch.push  = rx_stb & fifo_en_r;
    assign rx_fifo_ch.pop   = rx_pop & fifo_en_r;
    assign rx_fifo_ch.flush = flush;
    assign rx_fifo_ch.wdata = rx_char;

    // overrun: a char arrives while the store is full and not read now
    assign overrun_set = rx_stb & rx_full & ~rx_pop;

    // sticky overrun, cleared by a status read; a new event wins
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            overrun_r <= 1'b0;
        end else if (overrun_set) begin
            overrun_r <= 1'b1;
        end else if (acc_rd_stat) begin
            overrun_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // transmit path
    // ------------------------------------------------------------------

    // only the low byte is kept; upper write data is dropped
    assign tx_hold_ch.wdata = avs_writedata_i[7:0];
    assign tx_fifo_ch.wdata = avs_writedata_i[7:0];
    assign tx_hold_ch.push  = acc_wr_shadow & ~fifo_en_r;
    assign tx_fifo_ch.push  = acc_wr_shadow & fifo_en_r;
    assign tx_hold_ch.pop   = tx_pop & ~fifo_en_r;
    assign tx_fifo_ch.pop   = tx_pop & fifo_en_r;
    assign tx_hold_ch.flush = flush;
    assign tx_fifo_ch.flush = flush;

    // holding empty is the emptiness of whichever store is live
    assign tx_head  = fifo_en_r ? tx_fifo_ch.rdata : tx_hold_ch.rdata;
    assign tx_empty = fifo_en_r ? tx_fifo_ch.empty : tx_hold_ch.empty;
    assign tx_full  = fifo_en_r ? tx_fifo_ch.full  : tx_hold_ch.full;

    // hand the head over when the serialiser is idle; the gap after a
    // start lets the serialiser raise busy before the next is offered
    assign tx_pop = ~tx_busy_i & ~tx_start_r & ~tx_empty;

    // start pulse and character to the serialiser
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tx_start_r <= 1'b0;
            tx_char_r  <= `USDP_DATA_RESET;
        end else begin
            tx_start_r <= tx_pop;
            if (tx_pop) begin
                tx_char_r <= tx_head;
            end
        end
    end

    // ------------------------------------------------------------------
    // stores
    // ------------------------------------------------------------------

    // receive and transmit fifos, sixteen deep each
    usdp_fifo u_rx_fifo (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .ch        (rx_fifo_ch)
    );

    usdp_fifo u_tx_fifo (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .ch        (tx_fifo_ch)
    );

    // single character holding registers for the fifo-off mode
    usdp_hold u_rx_hold (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .ch        (rx_hold_ch)
    );

    usdp_hold u_tx_hold (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .ch        (tx_hold_ch)
    );

    // outputs straight from flops
    assign avs_readdata_o    = readdata_r;
    assign avs_waitrequest_o = waitrequest_r;
    assign tx_char_o         = tx_char_r;
    assign tx_start_o        = tx_start_r;
    assign tx_ir_sel_o       = ir_mode_r;

endmodule : usdp_port

// *** sim/usdp_far.sv ***
// far-end transceiver model: receive strobes and a slow serialiser
`timescale 1ns/1ns
module usdp_far (
    input  wire logic       mclk_i,      // system clock
    input  wire logic       tx_start_i,  // start pulse from the port
    input  wire logic [7:0] tx_char_i,   // char to send
    input  wire logic       tx_ir_sel_i, // infrared select
    output logic      [7:0] sin_char_o,  // serial char
    output logic            sin_valid_o, // serial strobe
    output logic      [7:0] sir_char_o,  // infrared char
    output logic            sir_valid_o, // infrared strobe
    output logic            tx_busy_o    // serialiser busy
);
    int         busy_len = 4; // cycles per char; raised to make the port wait
    int         busy_cnt = 0; // cycles left on the current char
    logic [8:0] got[$];       // {infrared, char} in send order

    initial begin
        sin_char_o = 8'h00;
        sin_valid_o = 1'b0;
        sir_char_o = 8'h00;
        sir_valid_o = 1'b0;
        tx_busy_o = 1'b0;
    end

    // serialiser: busy from the cycle after start for busy_len cycles
    always @(posedge mclk_i) begin
        if (tx_start_i) begin
            got.push_back({tx_ir_sel_i, tx_char_i});
            busy_cnt <= busy_len;
            tx_busy_o <= 1'b1;
        end else if (busy_cnt > 0) begin
            busy_cnt <= busy_cnt - 1;
            tx_busy_o <= (busy_cnt > 1);
        end
    end

    // one received char; the line then shows the inverse, not stale data
    task automatic send(input logic ir, input logic [7:0] c);
        @(posedge mclk_i);
        if (ir) begin
            sir_char_o <= c;
            sir_valid_o <= 1'b1;
        end else begin
            sin_char_o <= c;
            sin_valid_o <= 1'b1;
        end
        @(posedge mclk_i);
        sin_valid_o <= 1'b0;
        sir_valid_o <= 1'b0;
        sin_char_o <= ~c;
        sir_char_o <= ~c;
    endtask : send
endmodule : usdp_far

// *** sim/usdp_port_assertions.sv ***
// concurrent checks on the shadow data port pins
`timescale 1ns/1ns
module usdp_port_assertions (
    input  wire logic        mclk_i,            // system clock
    input  wire logic        reset_n_i,         // async reset, active low
    input  wire logic        avs_read_i,        // read request
    input  wire logic        avs_write_i,       // write request
    input  wire logic [31:0] avs_readdata_o,    // read data
    input  wire logic        avs_waitrequest_o, // high until answered
    input  wire logic        tx_busy_i,         // serialiser busy
    input  wire logic [7:0]  tx_char_o,         // char to serialise
    input  wire logic        tx_start_o,        // start pulse
    input  wire logic        tx_ir_sel_o        // send on infrared output
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);

    // answer edges: request still up while wait is low
    sequence s_rd_ans; avs_read_i && !avs_waitrequest_o; endsequence
    sequence s_wr_ans; avs_write_i && !avs_waitrequest_o; endsequence
    // a fresh request seen while the sequencer is idle
    sequence s_req_new; (avs_read_i || avs_write_i) && avs_waitrequest_o; endsequence

    AST_WAIT_ONE: assert property (s_req_new |=> !avs_waitrequest_o)
        else $error("request not answered one cycle later");
    AST_WAIT_PULSE: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    AST_UPPER_ZERO: assert property (s_rd_ans |-> avs_readdata_o[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    AST_READ_HOLD: assert property (!$stable(avs_readdata_o) |-> s_rd_ans)
        else $error("read data moved outside a read answer");
    AST_START_PULSE: assert property (tx_start_o |=> !tx_start_o)
        else $error("start pulse longer than one cycle");
    AST_START_IDLE: assert property (tx_start_o |-> $past(tx_busy_i) == 1'b0)
        else $error("start issued while serialiser busy");
    AST_CHAR_HOLD: assert property (!tx_start_o |-> $stable(tx_char_o))
        else $error("transmit char changed without a start");
    // the mode output is the control flop itself and changes right after the write answer; one more cycle is also allowed
    AST_IR_FOLLOW: assert property ($changed(tx_ir_sel_o) |->
        ($past(avs_write_i) && !$past(avs_waitrequest_o)) ||
        ($past(avs_write_i, 2) && !$past(avs_waitrequest_o, 2)))
        else $error("infrared select changed without a write");
endmodule : usdp_port_assertions

bind usdp_port usdp_port_assertions u_chk (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .tx_busy_i(tx_busy_i),
    .tx_char_o(tx_char_o), .tx_start_o(tx_start_o), .tx_ir_sel_o(tx_ir_sel_o));

// *** sim/usdp_port_tb.sv ***
// self-checking bench for the shadow data port
`timescale 1ns/1ns
`include "usdp_consts.svh"
module usdp_port_tb;
    logic        mclk_i = 1'b0;    // system clock
    logic        reset_n_i = 1'b0; // reset, active low
    logic [31:0] addr = 32'h0;     // bus address
    logic        rd = 1'b0;        // read request
    logic        wr = 1'b0;        // write request
    logic [31:0] wdata = 32'h0;    // write data
    logic [31:0] rdata;            // read data
    logic        wait_o;           // waitrequest
    logic [7:0]  sin_c;            // serial char
    logic [7:0]  sir_c;            // infrared char
    logic [7:0]  tx_c;             // char to send
    logic        sin_v;            // serial strobe
    logic        sir_v;            // infrared strobe
    logic        busy;             // serialiser busy
    logic        start;            // start pulse
    logic        irsel;            // infrared select
    logic [31:0] q;                // last read answer
    int          n_mismatch = 0;   // mismatches
    int          checked = 0;      // comparisons

    initial forever #50 mclk_i = ~mclk_i;

    usdp_port u_dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .avs_address_i(addr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
        .avs_byteenable_i(4'hf), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o),
        .sin_char_i(sin_c), .sin_char_valid_i(sin_v), .sir_char_i(sir_c),
        .sir_char_valid_i(sir_v), .tx_busy_i(busy), .tx_char_o(tx_c),
        .tx_start_o(start), .tx_ir_sel_o(irsel));
    usdp_far u_far (.mclk_i(mclk_i), .tx_start_i(start), .tx_char_i(tx_c),
        .tx_ir_sel_i(irsel), .sin_char_o(sin_c), .sin_valid_o(sin_v),
        .sir_char_o(sir_c), .sir_valid_o(sir_v), .tx_busy_o(busy));

    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string what);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, g, e);
        end
    endtask : chk

    // one bus cycle: hold until wait is sampled low, take data at that edge
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk_i);
        addr <= a;
        wdata <= d;
        rd <= !w;
        wr <= w;
        do begin
            @(posedge mclk_i);
            n++;
        end while (wait_o !== 1'b0 && n < 20);
        q = rdata;
        if (n >= 20) chk(32'h1, 32'h0, "bus answer");
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : xfer

    // wait, bounded, for the serialiser to have taken n chars
    task automatic wait_tx(input int n);
        int k;
        k = 0;
        while (u_far.got.size() < n && k < 3000) begin
            @(posedge mclk_i);
            k++;
        end
        repeat (120) @(posedge mclk_i);
        chk(u_far.got.size(), n, "chars sent");
    endtask : wait_tx

    task automatic t_reset;
        xfer(0, `USDP_SHADOW_3, 0);
        chk(q, 32'h0, "shadow 3 reset");
        xfer(0, `USDP_SHADOW_4, 0);
        chk(q, 32'h0, "shadow 4 reset");
        xfer(0, `USDP_STAT_OFS, 0);
        chk(q, 32'h20, "status reset");
        xfer(0, 32'h5000_1080, 0);
        chk(q, 32'h0, "unmapped read");
        $display("test reset done");
    endtask : t_reset

    // fifo off: overwrite with overrun, replace pending transmit char
    task automatic t_plain;
        u_far.send(0, 8'h5a);
        xfer(0, `USDP_STAT_OFS, 0);
        chk(q & 32'h3, 32'h1, "char available");
        xfer(0, `USDP_SHADOW_3, 0);
        chk(q, 32'h5a, "serial char");
        u_far.send(0, 8'h11);
        u_far.send(0, 8'h22);
        xfer(0, `USDP_STAT_OFS, 0);
        chk(q & 32'h3, 32'h3, "overrun");
        xfer(0, `USDP_SHADOW_4, 0);
        chk(q, 32'h22, "newest char kept");
        u_far.busy_len = 30;
        xfer(1, `USDP_SHADOW_3, 32'hffff_ff41);
        repeat (4) @(posedge mclk_i);
        xfer(1, `USDP_SHADOW_3, 32'h42);
        xfer(0, `USDP_STAT_OFS, 0);
        chk(q & 32'h20, 32'h0, "holding empty cleared");
        xfer(1, `USDP_SHADOW_4, 32'h43);
        wait_tx(2);
        chk(u_far.got[0], 32'h041, "first char");
        chk(u_far.got[1], 32'h043, "replaced char");
        $display("test fifo off done");
    endtask : t_plain

    task automatic t_ir;
        u_far.got.delete();
        xfer(1, `USDP_CTRL_OFS, 32'h2);
        u_far.send(1, 8'h3c);
        xfer(0, `USDP_SHADOW_LAST, 0);
        chk(q, 32'h3c, "infrared char");
        xfer(0, `USDP_STAT_OFS, 0);
        chk(q & 32'h20, 32'h20, "holding empty before write");
        xfer(1, `USDP_SHADOW_FIRST, 32'h81);
        wait_tx(1);
        chk(u_far.got[0], 32'h181, "infrared send");
        $display("test infrared done");
    endtask : t_ir

    // fifo on: sixteen deep each way, extra chars lost
    task automatic t_fifo;
        xfer(1, `USDP_CTRL_OFS, 32'h1);
        u_far.got.delete();
        u_far.busy_len = 100;
        for (int i = 0; i < 18; i++) begin
            if (i == 16) begin
                xfer(0, `USDP_STAT_OFS, 0);
                chk(q & 32'h8, 32'h0, "fifo not yet full");
            end
            xfer(1, `USDP_SHADOW_FIRST + 4 * (i % 16), 32'h60 + i);
        end
        xfer(0, `USDP_STAT_OFS, 0);
        chk(q & 32'h8, 32'h8, "tx fifo full");
        wait_tx(17);
        foreach (u_far.got[i]) chk(u_far.got[i], 32'h60 + i, "fifo order");
        for (int i = 0; i < 17; i++) u_far.send(0, 8'h80 + i);
        xfer(0, `USDP_STAT_OFS, 0);
        chk(q & 32'h7, 32'h7, "rx full overrun");
        for (int i = 0; i < 16; i++) begin
            xfer(0, `USDP_SHADOW_FIRST + 4 * i, 0);
            chk(q, 32'h80 + i, "rx fifo head");
        end
        xfer(0, `USDP_STAT_OFS, 0);
        chk(q & 32'h1, 32'h0, "extra char lost");
        $display("test fifo on done");
    endtask : t_fifo

    task automatic close_out;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out

    // watchdog: the whole run needs well under ten thousand cycles
    initial begin
        repeat (20000) @(posedge mclk_i);
        chk(32'h1, 32'h0, "watchdog");
        close_out();
    end

    initial begin
        repeat (12) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        t_reset();
        t_plain();
        t_ir();
        t_fifo();
        close_out();
    end
endmodule : usdp_port_tb
